// *** design/deflection_power_mode_sequencer.sv ***
// device end: serial register slave and power/mode sequencer
// assumes link pins and supply comparators are asynchronous to clk_sys
`timescale 1ns/1ps
module deflection_power_mode_sequencer #(
  parameter int DUTY_W = seq_pkg::DUTY_W,
  parameter int STEP_CYCLES = seq_pkg::RAMP_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // serial link pins
  seq_link_if.dev link,
  // supply comparators and monitors
  input wire logic vcc_above_por,
  input wire logic vcc_above_op,
  input wire logic vcc_above_low,
  input wire logic protect_trip,
  input wire logic sync_lock_locked,
  input wire logic buffer_load,
  // drive and mode outputs
  output seq_pkg::mode_e mode,
  output logic supply_enable,
  output logic [DUTY_W-1:0] line_drive_duty,
  output logic [DUTY_W-1:0] supply_drive_duty,
  output logic line_drive_oe,
  output logic supply_drive_oe,
  output logic vertical_out_oe,
  output logic sync_lock_loop_en,
  output logic drive_phase_loop_en,
  output logic sync_unlock_out,
  output logic sync_unlock_oe,
  output logic clamp_blank_output,
  // register readback
  input wire logic [4:0] reg_sel,
  output logic [7:0] reg_data
);
  import seq_pkg::*;

  localparam logic [DUTY_W-1:0] DUTY_MAX = '1;
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);
  localparam logic [4:0] REG_LIMIT = 5'(REG_COUNT);

  function automatic bus_phase_e next_phase(input bus_phase_e ph);
    unique case (ph)
      PH_ADDR: next_phase = PH_SUB;
      PH_SUB: next_phase = PH_DATA;
      PH_IDLE, PH_DATA, PH_SKIP: next_phase = PH_SKIP;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_sync_ff;
  logic [PIN_W-1:0] pin_prev_ff;

  assign pin_raw = {link.sda_line, link.scl_line, buffer_load, sync_lock_locked,
                    protect_trip, vcc_above_low, vcc_above_op, vcc_above_por};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  logic por_ok, op_ok, low_ok, prot_s, locked_s, buf_rise;
  logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;

  assign por_ok = pin_sync_ff[PIN_POR];
  assign op_ok = pin_sync_ff[PIN_OP];
  assign low_ok = pin_sync_ff[PIN_LOW];
  assign prot_s = pin_sync_ff[PIN_PROT];
  assign locked_s = pin_sync_ff[PIN_LOCK];
  assign buf_rise = pin_sync_ff[PIN_BUF] && !pin_prev_ff[PIN_BUF];
  assign scl_s = pin_sync_ff[PIN_SCL];
  assign sda_s = pin_sync_ff[PIN_SDA];
  assign scl_rise = scl_s && !pin_prev_ff[PIN_SCL];
  assign scl_fall = !scl_s && pin_prev_ff[PIN_SCL];
  assign start_det = scl_s && pin_prev_ff[PIN_SCL] && pin_prev_ff[PIN_SDA] && !sda_s;
  assign stop_det = scl_s && pin_prev_ff[PIN_SCL] && !pin_prev_ff[PIN_SDA] && sda_s;

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  mode_e state_ff;
  mode_e nxt_state;
  bus_phase_e phase_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] sub_ff;
  logic ack_oe_ff;
  logic accept;

  always_comb begin
    accept = 1'b0;
    if (state_ff != ST_POR) begin
      unique case (phase_ff)
        PH_ADDR: accept = (shift_ff == {CHIP_ADDR, 1'b0});
        PH_SUB: accept = (shift_ff[6:0] <= SUB_CTRL);
        PH_DATA: accept = 1'b1;
        PH_IDLE, PH_SKIP: accept = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_ff <= PH_IDLE;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 4'h0;
      sub_ff <= 8'h00;
      ack_oe_ff <= 1'b0;
    end else if (start_det) begin
      phase_ff <= PH_ADDR;
      bit_cnt_ff <= 4'h0;
      ack_oe_ff <= 1'b0;
    end else if (stop_det) begin
      phase_ff <= PH_IDLE;
      ack_oe_ff <= 1'b0;
    end else if (phase_ff != PH_IDLE) begin
      if (scl_rise) begin
        if (bit_cnt_ff != 4'h8) begin
          shift_ff <= {shift_ff[6:0], sda_s};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end else begin
          bit_cnt_ff <= 4'h0;
          phase_ff <= ack_oe_ff ? next_phase(phase_ff) : PH_SKIP;
        end
      end
      if (scl_fall) begin
        ack_oe_ff <= (bit_cnt_ff == 4'h8) && accept;
        if (bit_cnt_ff == 4'h8 && accept && phase_ff == PH_SUB) begin
          sub_ff <= shift_ff;
        end
      end
    end
  end

  assign link.dev_sda_oe = ack_oe_ff;
  assign link.dev_sda_out = 1'b0;

  logic wr_fire, wr_buf, wr_ctrl;
  logic [4:0] wr_idx;

  assign wr_fire = scl_fall && bit_cnt_ff == 4'h8 && phase_ff == PH_DATA && accept;
  assign wr_buf = sub_ff[SUB_MODE_BIT];
  assign wr_idx = sub_ff[4:0];
  assign wr_ctrl = wr_fire && sub_ff[6:0] == SUB_CTRL;

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  logic [7:0] active_mem [REG_COUNT];
  logic [7:0] shadow_mem [REG_COUNT];
  logic [REG_COUNT-1:0] pending_ff;
  logic [REG_COUNT-1:0] valid_ff;

  always_ff @(posedge clk_sys) begin
    if (buf_rise) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        if (pending_ff[i]) begin
          active_mem[i] <= shadow_mem[i];
        end
      end
    end
    if (wr_fire && !wr_buf) begin
      active_mem[wr_idx] <= shift_ff;
    end
    if (wr_fire && wr_buf) begin
      shadow_mem[wr_idx] <= shift_ff;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pending_ff <= '0;
      valid_ff <= '0;
    end else if (state_ff == ST_POR || state_ff == ST_STANDBY) begin
      pending_ff <= '0;
      valid_ff <= '0;
    end else begin
      if (buf_rise) begin
        valid_ff <= valid_ff | pending_ff;
        pending_ff <= '0;
      end
      if (wr_fire && wr_buf) begin
        pending_ff[wr_idx] <= 1'b1;
      end
      if (wr_fire && !wr_buf) begin
        valid_ff[wr_idx] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------
  logic supply_dis_ff, drive_rel_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      supply_dis_ff <= SUPPLY_DIS_RST;
      drive_rel_ff <= DRIVE_REL_RST;
    end else if (state_ff == ST_POR) begin
      supply_dis_ff <= SUPPLY_DIS_RST;
      drive_rel_ff <= DRIVE_REL_RST;
    end else if (wr_ctrl) begin
      supply_dis_ff <= shift_ff[SUPPLY_DIS_POS];
      drive_rel_ff <= shift_ff[DRIVE_REL_POS] && (op_ok || drive_rel_ff);
    end else if (prot_s) begin
      supply_dis_ff <= 1'b0;
      drive_rel_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mode machine and ramps
  // ----------------------------------------------------------------
  logic [15:0] step_cnt_ff;
  logic step_tick;
  logic [DUTY_W-1:0] line_duty_ff, supply_duty_ff;
  logic ramp_full, ramp_empty;

  assign step_tick = step_cnt_ff == STEP_LAST;
  assign ramp_full = line_duty_ff == DUTY_MAX && supply_duty_ff == DUTY_MAX;
  assign ramp_empty = line_duty_ff == '0 && supply_duty_ff == '0;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_POR: if (por_ok) nxt_state = ST_STANDBY;
      ST_STANDBY: if (!supply_dis_ff) nxt_state = ST_SUPPLY_ON;
      ST_SUPPLY_ON: begin
        if (supply_dis_ff) nxt_state = ST_STANDBY;
        else if (drive_rel_ff) nxt_state = ST_SOFT_START;
      end
      ST_SOFT_START: begin
        if (prot_s) nxt_state = ST_PROTECT;
        else if (!drive_rel_ff) nxt_state = ST_SOFT_DOWN;
        else if (ramp_full) nxt_state = ST_OPERATE;
      end
      ST_OPERATE: begin
        if (prot_s) nxt_state = ST_PROTECT;
        else if (!drive_rel_ff) nxt_state = ST_SOFT_DOWN;
      end
      ST_SOFT_DOWN: begin
        if (drive_rel_ff) nxt_state = ST_SOFT_START;
        else if (ramp_empty) nxt_state = ST_PROTECT;
      end
      ST_PROTECT: begin
        if (drive_rel_ff) nxt_state = ST_SOFT_START;
        else if (supply_dis_ff) nxt_state = ST_STANDBY;
      end
    endcase
    if (state_ff == ST_PROTECT ? !low_ok : !por_ok) begin
      nxt_state = ST_POR;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_POR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      step_cnt_ff <= 16'h0000;
    end else begin
      step_cnt_ff <= step_tick ? 16'h0000 : step_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      line_duty_ff <= '0;
      supply_duty_ff <= '0;
    end else if (state_ff == ST_SOFT_START && step_tick) begin
      if (line_duty_ff != DUTY_MAX) line_duty_ff <= line_duty_ff + 1'b1;
      if (supply_duty_ff != DUTY_MAX) supply_duty_ff <= supply_duty_ff + 1'b1;
    end else if (state_ff == ST_SOFT_DOWN && step_tick) begin
      if (supply_duty_ff != '0) supply_duty_ff <= supply_duty_ff - 1'b1;
      else if (line_duty_ff != '0) line_duty_ff <= line_duty_ff - 1'b1;
    end else if (state_ff != ST_SOFT_START && state_ff != ST_SOFT_DOWN
                 && state_ff != ST_OPERATE) begin
      line_duty_ff <= '0;
      supply_duty_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic running;

  assign running = state_ff == ST_SOFT_START || state_ff == ST_OPERATE
                   || state_ff == ST_SOFT_DOWN;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      supply_enable <= 1'b0;
      line_drive_oe <= 1'b0;
      supply_drive_oe <= 1'b0;
      vertical_out_oe <= 1'b0;
      sync_lock_loop_en <= 1'b0;
      drive_phase_loop_en <= 1'b0;
      sync_unlock_out <= 1'b1;
      sync_unlock_oe <= 1'b1;
      clamp_blank_output <= 1'b1;
      reg_data <= 8'h00;
    end else begin
      supply_enable <= state_ff != ST_POR && state_ff != ST_STANDBY;
      line_drive_oe <= running && op_ok;
      supply_drive_oe <= running && op_ok;
      vertical_out_oe <= running && op_ok;
      sync_lock_loop_en <= running;
      drive_phase_loop_en <= running;
      sync_unlock_out <= running ? !locked_s : 1'b1;
      sync_unlock_oe <= state_ff != ST_PROTECT;
      clamp_blank_output <= !running;
      if (reg_sel == SUB_CTRL[4:0]) begin
        reg_data <= {6'h00, drive_rel_ff, supply_dis_ff};
      end else if (reg_sel < REG_LIMIT && valid_ff[reg_sel]) begin
        reg_data <= active_mem[reg_sel];
      end else begin
        reg_data <= 8'h00;
      end
    end
  end

  assign mode = state_ff;
  assign line_drive_duty = line_duty_ff;
  assign supply_drive_duty = supply_duty_ff;

endmodule

// *** inc/seq_pkg.sv ***
// shared constants and types for the deflection power/mode sequencer link
// assumes one 100 MHz system clock on both ends
package seq_pkg;

  // ----------------------------------------------------------------
  // serial link addressing
  // ----------------------------------------------------------------
  localparam logic [6:0] CHIP_ADDR = 7'h2C; // arbitrary value
  localparam int SUB_MODE_BIT = 7;
  localparam logic [6:0] SUB_CTRL = 7'h1A;
  localparam int REG_COUNT = 27;

  // ----------------------------------------------------------------
  // control register fields and start values
  // ----------------------------------------------------------------
  localparam int SUPPLY_DIS_POS = 0;
  localparam int DRIVE_REL_POS = 1;
  localparam logic SUPPLY_DIS_RST = 1'b1;
  localparam logic DRIVE_REL_RST = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 100000;
  localparam int SUPPLY_WAIT_MS = 80;
  localparam int SUPPLY_WAIT_CYCLES = SUPPLY_WAIT_MS * CLK_KHZ;
  localparam int SCL_KHZ = 100;
  localparam int SCL_QUARTER_CYCLES = CLK_KHZ / (SCL_KHZ * 4);
  localparam int RAMP_STEP_CYCLES = 64;
  localparam int DUTY_W = 6;

  // ----------------------------------------------------------------
  // synchroniser lanes of the device
  // ----------------------------------------------------------------
  localparam int PIN_W = 8;
  localparam int PIN_POR = 0;
  localparam int PIN_OP = 1;
  localparam int PIN_LOW = 2;
  localparam int PIN_PROT = 3;
  localparam int PIN_LOCK = 4;
  localparam int PIN_BUF = 5;
  localparam int PIN_SCL = 6;
  localparam int PIN_SDA = 7;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR, ST_STANDBY, ST_SUPPLY_ON, ST_SOFT_START, ST_OPERATE, ST_SOFT_DOWN, ST_PROTECT
  } mode_e;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_SUB, PH_DATA, PH_SKIP} bus_phase_e;

  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} host_state_e;

endpackage

// *** inc/seq_link_if.sv ***
// open-drain two-wire link between the host and the sequencer
// assumes both ends share clk_sys; line levels are wired-and, low while any end enables a 0 output
`timescale 1ns/1ps
interface seq_link_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl_line;
  logic sda_line;

  assign scl_line = !(host_scl_oe && !host_scl_out);
  assign sda_line = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport host (
    output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
    input scl_line, sda_line
  );
  modport dev (
    output dev_sda_out, dev_sda_oe,
    input scl_line, sda_line
  );
endinterface

// *** design/deflection_host_sequencer.sv ***
// host end: issues one three-byte register write per command
// assumes the device shares clk_sys; sda is resynchronised here
`timescale 1ns/1ps
module deflection_host_sequencer #(
  parameter int QUARTER_CYCLES = seq_pkg::SCL_QUARTER_CYCLES,
  parameter int WAIT_CYCLES = seq_pkg::SUPPLY_WAIT_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // serial link pins
  seq_link_if.host link,
  // command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_sub,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic cmd_done,
  output logic cmd_nack,
  output logic supply_wait
);
  import seq_pkg::*;

  localparam logic [15:0] QUARTER_LAST = 16'(QUARTER_CYCLES - 1);

  // ----------------------------------------------------------------
  // sda synchroniser
  // ----------------------------------------------------------------
  logic sda_meta_ff, sda_sync_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
    end else begin
      sda_meta_ff <= link.sda_line;
      sda_sync_ff <= sda_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // supply settle timer
  // ----------------------------------------------------------------
  host_state_e hstate_ff;
  logic [31:0] wait_cnt_ff;
  logic supply_view_ff;
  logic is_ctrl, take;

  assign is_ctrl = cmd_sub[6:0] == SUB_CTRL;
  assign cmd_ready = hstate_ff == HS_IDLE
                     && !(is_ctrl && cmd_data[DRIVE_REL_POS] && wait_cnt_ff != 32'h0);
  assign take = cmd_valid && cmd_ready;
  assign supply_wait = wait_cnt_ff != 32'h0;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt_ff <= 32'h0;
      supply_view_ff <= SUPPLY_DIS_RST;
    end else if (take && is_ctrl) begin
      supply_view_ff <= cmd_data[SUPPLY_DIS_POS];
      if (!cmd_data[SUPPLY_DIS_POS] && supply_view_ff) begin
        wait_cnt_ff <= 32'(WAIT_CYCLES);
      end
    end else if (wait_cnt_ff != 32'h0) begin
      wait_cnt_ff <= wait_cnt_ff - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  logic [15:0] qcnt_ff;
  logic [1:0] qphase_ff;
  logic [3:0] bit_ff;
  logic [1:0] byte_ff;
  logic [7:0] tx_ff, sub_ff, data_ff;
  logic nack_ff, scl_oe_ff, sda_oe_ff;
  logic qtick;

  assign qtick = qcnt_ff == QUARTER_LAST;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hstate_ff <= HS_IDLE;
      qcnt_ff <= 16'h0000;
      qphase_ff <= 2'h0;
      bit_ff <= 4'h0;
      byte_ff <= 2'h0;
      tx_ff <= 8'h00;
      sub_ff <= 8'h00;
      data_ff <= 8'h00;
      nack_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      cmd_done <= 1'b0;
      cmd_nack <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      cmd_nack <= 1'b0;
      if (take) begin
        hstate_ff <= HS_START;
        sub_ff <= cmd_sub;
        data_ff <= cmd_data;
        tx_ff <= {CHIP_ADDR, 1'b0};
        byte_ff <= 2'h0;
        bit_ff <= 4'h0;
        qphase_ff <= 2'h0;
        qcnt_ff <= 16'h0000;
        nack_ff <= 1'b0;
      end else if (hstate_ff != HS_IDLE) begin
        qcnt_ff <= qtick ? 16'h0000 : qcnt_ff + 16'h0001;
        if (qtick) begin
          qphase_ff <= qphase_ff + 2'h1;
          unique case (hstate_ff)
            HS_START: begin
              if (qphase_ff == 2'h1) sda_oe_ff <= 1'b1;
              if (qphase_ff == 2'h3) begin
                scl_oe_ff <= 1'b1;
                hstate_ff <= HS_BIT;
              end
            end
            HS_BIT: begin
              if (qphase_ff == 2'h0) sda_oe_ff <= bit_ff != 4'h8 && !tx_ff[7];
              if (qphase_ff == 2'h1) scl_oe_ff <= 1'b0;
              if (qphase_ff == 2'h2 && bit_ff == 4'h8 && sda_sync_ff) nack_ff <= 1'b1;
              if (qphase_ff == 2'h3) begin
                scl_oe_ff <= 1'b1;
                if (bit_ff != 4'h8) begin
                  tx_ff <= {tx_ff[6:0], 1'b0};
                  bit_ff <= bit_ff + 4'h1;
                end else begin
                  bit_ff <= 4'h0;
                  if (nack_ff || byte_ff == 2'h2) begin
                    hstate_ff <= HS_STOP;
                  end else begin
                    byte_ff <= byte_ff + 2'h1;
                    tx_ff <= byte_ff == 2'h0 ? sub_ff : data_ff;
                  end
                end
              end
            end
            HS_STOP: begin
              if (qphase_ff == 2'h0) sda_oe_ff <= 1'b1;
              if (qphase_ff == 2'h1) scl_oe_ff <= 1'b0;
              if (qphase_ff == 2'h2) sda_oe_ff <= 1'b0;
              if (qphase_ff == 2'h3) begin
                hstate_ff <= HS_IDLE;
                cmd_done <= 1'b1;
                cmd_nack <= nack_ff;
              end
            end
            HS_IDLE: begin
            end
          endcase
        end
      end
    end
  end

  assign link.host_scl_oe = scl_oe_ff;
  assign link.host_scl_out = 1'b0;
  assign link.host_sda_oe = sda_oe_ff;
  assign link.host_sda_out = 1'b0;

endmodule

// *** tb/seq_properties.sv ***
// checker: sequencer relations on the link and device outputs
// assumes one clock clk_sys and async reset sys_rst
`timescale 1ns/1ps
module seq_properties #(parameter int DUTY_W = 6) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // watched signals
  input wire logic dev_sda_oe,
  input seq_pkg::mode_e mode,
  input wire logic vcc_above_op,
  input wire logic sync_lock_locked,
  input wire logic supply_enable,
  input wire logic sync_unlock_out,
  input wire logic sync_unlock_oe,
  input wire logic line_drive_oe,
  input wire logic supply_drive_oe,
  input wire logic vertical_out_oe,
  input wire logic sync_lock_loop_en,
  input wire logic drive_phase_loop_en,
  input wire logic clamp_blank_output,
  input wire logic [DUTY_W-1:0] line_drive_duty,
  input wire logic [DUTY_W-1:0] supply_drive_duty
);
  import seq_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_mute; mode == ST_POR && $past(mode) == ST_POR |-> !dev_sda_oe; endproperty
  a_mute: assert property (p_mute) else $error("ack in power-on clear");
  property p_idle; mode inside {ST_STANDBY, ST_SUPPLY_ON} && $past(mode) == mode
    |-> sync_unlock_out && !line_drive_oe && !vertical_out_oe; endproperty
  a_idle: assert property (p_idle) else $error("idle outputs wrong");
  property p_sup; mode inside {ST_STANDBY, ST_SUPPLY_ON} && $past(mode) == mode
    |-> supply_enable == (mode == ST_SUPPLY_ON); endproperty
  a_sup: assert property (p_sup) else $error("supply enable wrong");
  property p_start; (mode == ST_SOFT_START && vcc_above_op) [*4]
    |-> sync_lock_loop_en && drive_phase_loop_en && vertical_out_oe; endproperty
  a_start: assert property (p_start) else $error("soft start outputs off");
  property p_unl; (mode == ST_OPERATE && $stable(sync_lock_locked)) [*4]
    |-> sync_unlock_out == !sync_lock_locked; endproperty
  a_unl: assert property (p_unl) else $error("unlock level wrong");
  property p_keep; $past(mode) == ST_OPERATE && mode != ST_OPERATE
    |-> mode inside {ST_SOFT_DOWN, ST_PROTECT, ST_POR}; endproperty
  a_keep: assert property (p_keep) else $error("bad exit from operation");
  property p_down; mode == ST_SOFT_DOWN && line_drive_duty < $past(line_drive_duty)
    |-> supply_drive_duty == 0; endproperty
  a_down: assert property (p_down) else $error("line ramp before supply ramp");
  property p_prot; mode == ST_PROTECT && $past(mode) == ST_PROTECT |-> !sync_unlock_oe
    && clamp_blank_output && !line_drive_oe && !supply_drive_oe && !vertical_out_oe
    && !sync_lock_loop_en && !drive_phase_loop_en; endproperty
  a_prot: assert property (p_prot) else $error("protection outputs wrong");
  property p_pexit; $past(mode) == ST_PROTECT && mode != ST_PROTECT
    |-> mode inside {ST_STANDBY, ST_SOFT_START, ST_POR}; endproperty
  a_pexit: assert property (p_pexit) else $error("bad exit from protection");
  property p_low; !vcc_above_op [*4] |-> !line_drive_oe && !supply_drive_oe
    && !vertical_out_oe; endproperty
  a_low: assert property (p_low) else $error("drive active at low supply");
endmodule

// *** tb/tb_top.sv ***
// testbench: host and device joined over the link
// assumes seq_pkg, seq_link_if and both design ends compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import seq_pkg::*;
  logic clk_sys = 0, sys_rst = 1, vcc_above_por = 0, vcc_above_op = 0, vcc_above_low = 1;
  logic protect_trip = 0, sync_lock_locked = 0, buffer_load = 0, cmd_valid = 0;
  logic [7:0] cmd_sub = '0, cmd_data = '0, reg_data;
  logic [4:0] reg_sel = '0;
  logic cmd_ready, cmd_done, cmd_nack, supply_wait, supply_enable, line_drive_oe;
  logic supply_drive_oe, vertical_out_oe, sync_lock_loop_en, drive_phase_loop_en;
  logic sync_unlock_out, sync_unlock_oe, clamp_blank_output;
  logic [5:0] line_drive_duty, supply_drive_duty;
  mode_e mode;
  int num_errors = 0, total_checks = 0, cyc = 0;
  seq_link_if link();
  always #5 clk_sys = ~clk_sys;
  deflection_host_sequencer #(.QUARTER_CYCLES(4), .WAIT_CYCLES(600))
    deflection_host_sequencer_inst (.clk_sys, .sys_rst, .link(link.host), .cmd_valid,
    .cmd_sub, .cmd_data, .cmd_ready, .cmd_done, .cmd_nack, .supply_wait);
  deflection_power_mode_sequencer #(.DUTY_W(6), .STEP_CYCLES(2))
    deflection_power_mode_sequencer_inst (.clk_sys, .sys_rst, .link(link.dev), .vcc_above_por,
    .vcc_above_op, .vcc_above_low, .protect_trip, .sync_lock_locked, .buffer_load, .mode,
    .supply_enable, .line_drive_duty, .supply_drive_duty, .line_drive_oe, .supply_drive_oe,
    .vertical_out_oe, .sync_lock_loop_en, .drive_phase_loop_en, .sync_unlock_out,
    .sync_unlock_oe, .clamp_blank_output, .reg_sel, .reg_data);
  seq_properties #(.DUTY_W(6)) seq_properties_inst (.clk_sys, .sys_rst,
    .dev_sda_oe(link.dev_sda_oe), .mode, .vcc_above_op, .sync_lock_locked, .supply_enable,
    .sync_unlock_out, .sync_unlock_oe, .line_drive_oe, .supply_drive_oe, .vertical_out_oe,
    .sync_lock_loop_en, .drive_phase_loop_en, .clamp_blank_output, .line_drive_duty,
    .supply_drive_duty);
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] s, input logic [7:0] d, input logic en);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmd_sub <= s;
    cmd_data <= d;
    cmd_valid <= 1'b1;
    do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 2000);
    cmd_valid <= 1'b0;
    do @(posedge clk_sys); while (cmd_done !== 1'b1 && ++n < 4000);
    `CHK("done", 1'b1, cmd_done)
    `CHK("nack", en, cmd_nack)
  endtask
  task automatic wait_mode(input mode_e m);
    int n;
    n = 0;
    while (mode !== m && n < 900) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (2) @(negedge clk_sys);
    `CHK("mode", m, mode)
  endtask
  task automatic rd(input logic [4:0] i, input logic [7:0] e);
    @(posedge clk_sys);
    reg_sel <= i;
    repeat (3) @(negedge clk_sys);
    `CHK("reg", e, reg_data)
  endtask
  task automatic t_power;
    wr(8'h01, 8'h55, 1'b1);
    `CHK("por", ST_POR, mode)
    @(posedge clk_sys);
    vcc_above_por <= 1'b1;
    wait_mode(ST_STANDBY);
    rd(5'h1A, 8'h01);
    `CHK("unlock", 1'b1, sync_unlock_out)
    wr(8'h1B, 8'h00, 1'b1);
    wr(8'h1A, 8'h00, 1'b0);
    wait_mode(ST_SUPPLY_ON);
    `CHK("settle", 1'b1, supply_wait)
    `CHK("supply", 1'b1, supply_enable)
    wr(8'h1A, 8'h02, 1'b0);
    rd(5'h1A, 8'h00);
    `CHK("mode", ST_SUPPLY_ON, mode)
    `CHK("drive", 1'b0, line_drive_oe)
    $display("power test done");
  endtask
  task automatic t_run;
    @(posedge clk_sys);
    vcc_above_op <= 1'b1;
    sync_lock_locked <= 1'b1;
    wr(8'h1A, 8'h02, 1'b0);
    wait_mode(ST_OPERATE);
    `CHK("duty", 6'h3F, line_drive_duty)
    `CHK("bduty", 6'h3F, supply_drive_duty)
    `CHK("unlock", 1'b0, sync_unlock_out)
    wr(8'h01, 8'h55, 1'b0);
    rd(5'h01, 8'h55);
    `CHK("mode", ST_OPERATE, mode)
    @(posedge clk_sys);
    sync_lock_locked <= 1'b0;
    repeat (5) @(negedge clk_sys);
    `CHK("unlock", 1'b1, sync_unlock_out)
    wr(8'h1A, 8'h00, 1'b0);
    wait_mode(ST_PROTECT);
    $display("run test done");
  endtask
  task automatic t_protect;
    `CHK("blank", 1'b1, clamp_blank_output)
    `CHK("float", 1'b0, sync_unlock_oe)
    rd(5'h01, 8'h55);
    wr(8'h81, 8'hAA, 1'b0);
    rd(5'h01, 8'h55);
    @(posedge clk_sys);
    buffer_load <= 1'b1;
    repeat (4) @(posedge clk_sys);
    buffer_load <= 1'b0;
    rd(5'h01, 8'hAA);
    wr(8'h9A, 8'h02, 1'b0);
    wait_mode(ST_OPERATE);
    @(posedge clk_sys);
    protect_trip <= 1'b1;
    wait_mode(ST_PROTECT);
    @(posedge clk_sys);
    protect_trip <= 1'b0;
    rd(5'h1A, 8'h00);
    wr(8'h1A, 8'h01, 1'b0);
    wait_mode(ST_STANDBY);
    rd(5'h01, 8'h00);
    $display("protect test done");
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_power();
    t_run();
    t_protect();
    complete_run();
  end
endmodule
